// *** src/lfr_top.sv ***
// LED driver I2C register bank with overcurrent and thermal fault supervision
`include "lfr_cfg.svh"

// Summary of operation
// - Two-bit overcurrent threshold select, four settings, applied to low-side switch.
// - Overcurrent crossing turns low-side switch off until next switching period.
// - Overcurrent flag sets after eight windows each with two or more events.
// - Overcurrent events not counted toward flag for 4 ms after start-up and brightness change.
// - Fault control bit 1 picks shutdown or report-only for overcurrent flag.
// - After forced shutdown, enable refused until fault flags are read.
// - Thermal trip halts boost and sets flag; recovery restarts switching automatically.
// - Fault control bit 2 picks thermal shutdown; flags read unlocks re-enable.
// - Bus busy from START to STOP; repeated START behaves like START.
// - Respond only to seven-bit address 0x36 followed by direction bit.
// - Address, register index, then data byte written to indexed register.
// - Bytes eight bits MSB first; target acknowledges each received byte.
// - Reserved bits and write-only registers read as zero.
// - Index 0x00 returns four-bit revision code, upper nibble zero.
// - Writing one to soft reset bit resets device; bit self-clears.
// - Enable register holds device enable and three string enables, all default on.
// - Device enable rising reloads brightness bit 0 and PWM control defaults.
// - Brightness control holds mapping, brightness mode and adjust-input polarity.
// - Brightness control holds ramp enable and three-bit ramp rate.
// - PWM control holds sample rate and input polarity.
// - PWM control holds hysteresis and pulse filter fields.
// - Shutdown-disable bits 2:0 (thermal, overcurrent, overvoltage): zero forces shutdown on flag; one only reports.
// - Flags: open bit 4, short 3, thermal 2, overcurrent 1, overvoltage 0.
module lfr_top #(
    parameter int unsigned OCP_WIN_CYCLES = `LFR_OCP_WIN_NS / `LFR_CLK_PERIOD_NS,
    parameter int unsigned OCP_BLANK_CYCLES = `LFR_OCP_BLANK_NS / `LFR_CLK_PERIOD_NS
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire lfr_pkg::lfr_fault_pins_t fault_pins_in,
    input wire logic brightness_change_in,
    output logic [3:0] enable_out,
    output logic [7:0] brightness_control_out,
    output logic [7:0] pwm_control_out,
    output logic [1:0] ocp_threshold_out,
    output logic low_side_switch_off_out,
    output logic boost_halt_out,
    output logic [4:0] fault_flags_out
);
    // Synchronised pins
    logic [1:0] bus_lvl;
    lfr_pkg::lfr_fault_pins_t flt_lvl;
    logic [1:0] bus_d_reg;
    lfr_pkg::lfr_fault_pins_t flt_d_reg;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic oc_evt, therm_rise, therm_rec, period_start;
    // Bus target state
    lfr_pkg::lfr_i2c_state_t st_reg, st_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] idx_reg, idx_next;
    logic nack_reg, nack_next;
    logic oe_reg, oe_next;
    logic sda_lvl_reg;
    logic wr_reg, wr_next;
    logic [7:0] wdat_reg, wdat_next;
    logic [7:0] widx_reg, widx_next;
    logic frd_reg, frd_next;
    logic [7:0] rd_data;
    // Register and fault state
    logic [3:0] en_reg, en_next;
    logic [7:0] bri_reg, bri_next;
    logic [7:0] pwm_reg, pwm_next;
    logic [1:0] ocs_reg, ocs_next;
    logic [3:0] fctl_reg, fctl_next;
    logic [4:0] flags_reg, flags_next;
    logic lock_reg, lock_next;
    logic srst_pulse_reg, srst_pulse_next;
    logic [19:0] win_reg, win_next;
    logic [19:0] blank_reg, blank_next;
    logic [1:0] evc_reg, evc_next;
    logic [2:0] cons_reg, cons_next;
    logic lso_reg, lso_next;
    logic halt_reg, halt_next;
    logic [4:0] set_vec;
    logic shutdown;
    logic int_rst;

    assign int_rst = srst_in | srst_pulse_reg;

    // Bus pins and fault indications pass four flops each
    lfr_sync #(.WIDTH(2)) u_bus_sync (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .async_in({scl_in, sda_in}),
        .rst_val_in(2'b11),
        .level_out(bus_lvl)
    );
    lfr_sync #(.WIDTH(7)) u_flt_sync (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .async_in(fault_pins_in),
        .rst_val_in(7'h00),
        .level_out(flt_lvl)
    );

    // Edge and condition detection on filtered levels
    assign scl_rise = bus_lvl[1] & ~bus_d_reg[1];
    assign scl_fall = ~bus_lvl[1] & bus_d_reg[1];
    assign start_det = bus_lvl[1] & bus_d_reg[1] & bus_d_reg[0] & ~bus_lvl[0];
    assign stop_det = bus_lvl[1] & bus_d_reg[1] & ~bus_d_reg[0] & bus_lvl[0];
    assign oc_evt = flt_lvl.over_current_limit & ~flt_d_reg.over_current_limit;
    assign therm_rise = flt_lvl.thermal_trip & ~flt_d_reg.thermal_trip;
    assign therm_rec = flt_lvl.thermal_recover & ~flt_d_reg.thermal_recover;
    assign period_start = flt_lvl.switch_period & ~flt_d_reg.switch_period;

    // Read multiplexer; unlisted and reserved bits read zero
    always_comb
    begin
        case (idx_reg)
            `LFR_IDX_REVISION: rd_data = {4'h0, `LFR_REVISION_CODE};
            `LFR_IDX_ENABLE: rd_data = {4'h0, en_reg};
            `LFR_IDX_BRIGHTNESS: rd_data = bri_reg;
            `LFR_IDX_PWM: rd_data = pwm_reg;
            `LFR_IDX_BOOST: rd_data = {6'h00, ocs_reg};
            `LFR_IDX_FAULT_CTRL: rd_data = {4'h0, fctl_reg};
            `LFR_IDX_FAULT_FLAGS: rd_data = {3'h0, flags_reg};
            default: rd_data = 8'h00;
        endcase
    end

    // Bus target sequencing: shifts on SCL rise, drives SDA on SCL fall
    always_comb
    begin
        st_next = st_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        idx_next = idx_reg;
        nack_next = nack_reg;
        oe_next = oe_reg;
        wr_next = 1'b0;
        wdat_next = wdat_reg;
        widx_next = widx_reg;
        frd_next = 1'b0;
        if (start_det)
        begin
            st_next = lfr_pkg::ST_ADDR;
            bit_next = 4'h0;
            oe_next = 1'b0;
        end
        else if (stop_det)
        begin
            st_next = lfr_pkg::ST_IDLE;
            oe_next = 1'b0;
        end
        else if (st_reg != lfr_pkg::ST_IDLE && st_reg != lfr_pkg::ST_IGNORE)
        begin
            if (scl_rise)
            begin
                if (bit_reg < 4'h8)
                begin
                    sh_next = {sh_reg[6:0], bus_lvl[0]};
                    bit_next = bit_reg + 4'h1;
                end
                else if (bit_reg == 4'h8)
                begin
                    nack_next = bus_lvl[0];
                    bit_next = 4'h9;
                end
            end
            else if (scl_fall)
            begin
                if (bit_reg == 4'h8)
                begin
                    oe_next = 1'b1;
                    case (st_reg)
                        lfr_pkg::ST_ADDR:
                        begin
                            nack_next = 1'b0;
                            if (sh_reg[7:1] == `LFR_I2C_ADDR)
                                st_next = sh_reg[0] ? lfr_pkg::ST_RDATA : lfr_pkg::ST_IDX;
                            else
                            begin
                                st_next = lfr_pkg::ST_IGNORE;
                                oe_next = 1'b0;
                            end
                        end
                        lfr_pkg::ST_IDX:
                        begin
                            idx_next = sh_reg;
                            st_next = lfr_pkg::ST_WDATA;
                        end
                        lfr_pkg::ST_WDATA:
                        begin
                            wr_next = 1'b1;
                            wdat_next = sh_reg;
                            widx_next = idx_reg;
                            idx_next = idx_reg + 8'h01;
                        end
                        default: oe_next = 1'b0;
                    endcase
                end
                else if (bit_reg == 4'h9)
                begin
                    bit_next = 4'h0;
                    oe_next = 1'b0;
                    if (st_reg == lfr_pkg::ST_RDATA)
                    begin
                        if (nack_reg)
                            st_next = lfr_pkg::ST_IGNORE;
                        else
                        begin
                            tx_next = rd_data;
                            oe_next = ~rd_data[7];
                            idx_next = idx_reg + 8'h01;
                            frd_next = (idx_reg == `LFR_IDX_FAULT_FLAGS);
                        end
                    end
                end
                else if (st_reg == lfr_pkg::ST_RDATA && bit_reg != 4'h0)
                begin
                    tx_next = {tx_reg[6:0], 1'b0};
                    oe_next = ~tx_reg[6];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            bus_d_reg <= 2'b11;
            flt_d_reg <= '0;
            st_reg <= lfr_pkg::ST_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            idx_reg <= 8'h00;
            nack_reg <= 1'b0;
            oe_reg <= 1'b0;
            sda_lvl_reg <= 1'b0;
            wr_reg <= 1'b0;
            wdat_reg <= 8'h00;
            widx_reg <= 8'h00;
            frd_reg <= 1'b0;
        end
        else
        begin
            bus_d_reg <= bus_lvl;
            flt_d_reg <= flt_lvl;
            st_reg <= st_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            idx_reg <= idx_next;
            nack_reg <= nack_next;
            oe_reg <= oe_next;
            sda_lvl_reg <= 1'b0;
            wr_reg <= wr_next;
            wdat_reg <= wdat_next;
            widx_reg <= widx_next;
            frd_reg <= frd_next;
        end
    end

    // Flag set sources; short detection only when enabled
    always_comb
    begin
        set_vec = 5'h00;
        set_vec[`LFR_FLAG_OVP] = flt_lvl.over_voltage_limit & ~flt_d_reg.over_voltage_limit;
        set_vec[`LFR_FLAG_OCP] = (win_reg == 20'(OCP_WIN_CYCLES - 1)) && (cons_reg == 3'(`LFR_OCP_WINDOWS - 1))
            && (evc_reg >= 2'(`LFR_OCP_MIN_EVENTS)) && (blank_reg == 20'h0_0000) && en_reg[0];
        set_vec[`LFR_FLAG_THERM] = therm_rise;
        set_vec[`LFR_FLAG_SHORT] = fctl_reg[`LFR_FCTL_SHORT_EN] & flt_lvl.short_string & ~flt_d_reg.short_string;
        set_vec[`LFR_FLAG_OPEN] = flt_lvl.open_string & ~flt_d_reg.open_string;
        shutdown = |(set_vec[2:0] & ~fctl_reg[2:0]) & en_reg[0];
    end

    // Register file and fault supervision
    always_comb
    begin
        en_next = en_reg;
        bri_next = bri_reg;
        pwm_next = pwm_reg;
        ocs_next = ocs_reg;
        fctl_next = fctl_reg;
        lock_next = lock_reg;
        srst_pulse_next = 1'b0;
        if (wr_reg)
        begin
            case (widx_reg)
                `LFR_IDX_SOFT_RESET: srst_pulse_next = wdat_reg[0];
                `LFR_IDX_ENABLE:
                begin
                    en_next = wdat_reg[3:0];
                    if (lock_reg)
                        en_next[`LFR_EN_DEVICE] = 1'b0;
                    else if (wdat_reg[0] && !en_reg[0])
                    begin
                        bri_next[`LFR_BRIGHT_ADJ_POL] = 1'(`LFR_BRIGHT_RST >> `LFR_BRIGHT_ADJ_POL);
                        pwm_next = `LFR_PWM_RST;
                    end
                end
                `LFR_IDX_BRIGHTNESS: bri_next = wdat_reg;
                `LFR_IDX_PWM: pwm_next = wdat_reg;
                `LFR_IDX_BOOST: ocs_next = wdat_reg[1:0];
                `LFR_IDX_FAULT_CTRL: fctl_next = wdat_reg[3:0];
                default: ;
            endcase
        end
        if (frd_reg)
            lock_next = 1'b0;
        if (shutdown)
        begin
            en_next[`LFR_EN_DEVICE] = 1'b0;
            lock_next = 1'b1;
        end
        // Set wins over the read clear
        flags_next = (flags_reg & ~{5{frd_reg}}) | set_vec;
        // Low-side switch off for the rest of the period; thermal halt until recovery
        lso_next = oc_evt ? 1'b1 : (period_start ? 1'b0 : lso_reg);
        halt_next = therm_rise ? 1'b1 : (therm_rec ? 1'b0 : halt_reg);
        // Overcurrent density filter
        win_next = win_reg;
        blank_next = blank_reg;
        evc_next = evc_reg;
        cons_next = cons_reg;
        if (!en_reg[0])
        begin
            win_next = 20'h0_0000;
            blank_next = 20'(OCP_BLANK_CYCLES);
            evc_next = 2'h0;
            cons_next = 3'h0;
        end
        else if (brightness_change_in || blank_reg != 20'h0_0000)
        begin
            blank_next = brightness_change_in ? 20'(OCP_BLANK_CYCLES) : blank_reg - 20'h0_0001;
            win_next = 20'h0_0000;
            evc_next = 2'h0;
            cons_next = 3'h0;
        end
        else if (win_reg == 20'(OCP_WIN_CYCLES - 1))
        begin
            win_next = 20'h0_0000;
            evc_next = 2'h0;
            if (evc_reg >= 2'(`LFR_OCP_MIN_EVENTS) && cons_reg != 3'(`LFR_OCP_WINDOWS - 1))
                cons_next = cons_reg + 3'h1;
            else
                cons_next = 3'h0;
        end
        else
        begin
            win_next = win_reg + 20'h0_0001;
            if (oc_evt && evc_reg != 2'h3)
                evc_next = evc_reg + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (int_rst)
        begin
            en_reg <= `LFR_ENABLE_RST;
            bri_reg <= `LFR_BRIGHT_RST;
            pwm_reg <= `LFR_PWM_RST;
            ocs_reg <= `LFR_OCP_SEL_RST;
            fctl_reg <= `LFR_FAULT_CTRL_RST;
            flags_reg <= 5'h00;
            lock_reg <= 1'b0;
            win_reg <= 20'h0_0000;
            blank_reg <= 20'(OCP_BLANK_CYCLES);
            evc_reg <= 2'h0;
            cons_reg <= 3'h0;
            lso_reg <= 1'b0;
            halt_reg <= 1'b0;
        end
        else
        begin
            en_reg <= en_next;
            bri_reg <= bri_next;
            pwm_reg <= pwm_next;
            ocs_reg <= ocs_next;
            fctl_reg <= fctl_next;
            flags_reg <= flags_next;
            lock_reg <= lock_next;
            win_reg <= win_next;
            blank_reg <= blank_next;
            evc_reg <= evc_next;
            cons_reg <= cons_next;
            lso_reg <= lso_next;
            halt_reg <= halt_next;
        end
    end

    // Soft reset pulse clears itself after one cycle
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            srst_pulse_reg <= 1'b0;
        else
            srst_pulse_reg <= srst_pulse_next;
    end

    // Outputs straight from flops
    assign sda_out = sda_lvl_reg;
    assign sda_oe_out = oe_reg;
    assign enable_out = en_reg;
    assign brightness_control_out = bri_reg;
    assign pwm_control_out = pwm_reg;
    assign ocp_threshold_out = ocs_reg;
    assign low_side_switch_off_out = lso_reg;
    assign boost_halt_out = halt_reg;
    assign fault_flags_out = flags_reg;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (int_rst);

    ocp_flag_cause_a: assert property ($rose(flags_reg[1]) |-> $past(cons_reg) == 3'h7)
        else $error("overcurrent flag set without eight qualifying windows");
    blank_hold_a: assert property ((blank_reg != 20'h0_0000) |=> (cons_reg == 3'h0) && (evc_reg == 2'h0))
        else $error("overcurrent counting during blank time");
    switch_off_a: assert property (oc_evt |=> lso_reg)
        else $error("low-side switch not turned off on overcurrent");
    forced_shutdown_a: assert property ((shutdown) |=> !en_reg[0] && lock_reg)
        else $error("forced shutdown did not disable and lock");
    enable_lock_a: assert property (lock_reg |-> !en_reg[0])
        else $error("device enabled while re-enable is locked");
    thermal_halt_a: assert property (therm_rise |=> halt_reg && flags_reg[2])
        else $error("thermal trip did not halt boost and set flag");
    addr_ack_a: assert property ((scl_fall && bit_reg == 4'h8 && st_reg == lfr_pkg::ST_ADDR && !start_det
        && !stop_det) |=> (oe_reg == (sh_reg[7:1] == `LFR_I2C_ADDR)))
        else $error("address acknowledge wrong");
    stop_idle_a: assert property (stop_det && !start_det |=> st_reg == lfr_pkg::ST_IDLE)
        else $error("bus not idle after stop");
    enable_reload_a: assert property ($rose(en_reg[0]) |-> pwm_reg == `LFR_PWM_RST && bri_reg[0])
        else $error("enable did not reload defaults");
endmodule

// *** src/lfr_cfg.svh ***
// Register offsets, field positions, reset values and timing figures of the LED fault and I2C block
`ifndef LFR_CFG_SVH
`define LFR_CFG_SVH

// Bus target address and register indices
`define LFR_I2C_ADDR 7'h36
`define LFR_IDX_REVISION 8'h00
`define LFR_IDX_SOFT_RESET 8'h01
`define LFR_IDX_ENABLE 8'h10
`define LFR_IDX_BRIGHTNESS 8'h11
`define LFR_IDX_PWM 8'h12
`define LFR_IDX_BOOST 8'h13
`define LFR_IDX_FAULT_CTRL 8'h1E
`define LFR_IDX_FAULT_FLAGS 8'h1F

// Revision code, arbitrary value
`define LFR_REVISION_CODE 4'h1

// Reset values
`define LFR_ENABLE_RST 4'hF
`define LFR_BRIGHT_RST 8'h61
`define LFR_PWM_RST 8'h73
`define LFR_OCP_SEL_RST 2'h3
`define LFR_FAULT_CTRL_RST 4'h7

// Field positions
`define LFR_EN_DEVICE 0
`define LFR_BRIGHT_ADJ_POL 0
`define LFR_FLAG_OVP 0
`define LFR_FLAG_OCP 1
`define LFR_FLAG_THERM 2
`define LFR_FLAG_SHORT 3
`define LFR_FLAG_OPEN 4
`define LFR_FCTL_SHORT_EN 3

// Overcurrent filter figures
`define LFR_CLK_PERIOD_NS 4
`define LFR_OCP_WIN_NS 128000
`define LFR_OCP_BLANK_NS 4000000
`define LFR_OCP_MIN_EVENTS 2
`define LFR_OCP_WINDOWS 8

`endif

// *** src/lfr_pkg.sv ***
// Types shared by the LED fault and I2C block
package lfr_pkg;

    // Asynchronous indications from the analog side
    typedef struct packed {
        logic open_string;
        logic short_string;
        logic over_voltage_limit;
        logic switch_period;
        logic thermal_recover;
        logic thermal_trip;
        logic over_current_limit;
    } lfr_fault_pins_t;

    // Bus target sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_IDX = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_IGNORE = 3'b101
    } lfr_i2c_state_t;

endpackage

// *** src/lfr_sync.sv ***
// Three-stage input synchroniser whose output moves once stages two and three agree
module lfr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] rst_val_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // Filtered level follows only bits where stages two and three agree
    always_comb
    begin
        level_next = (level_reg & (s2_reg ^ s3_reg)) | (s2_reg & ~(s2_reg ^ s3_reg));
    end

    // Stage registers; the first stage feeds only the second
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            s1_reg <= rst_val_in;
            s2_reg <= rst_val_in;
            s3_reg <= rst_val_in;
            level_reg <= rst_val_in;
        end
        else
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    // Filtered level straight from its flop; reset loads the idle level of the pin
    assign level_out = level_reg;
endmodule

// *** verification/lfr_host_model.sv ***
// Bus host master model for the LED fault and register block
`include "lfr_cfg.svh"
module lfr_host_model (
    input wire logic sys_clk_in,
    input wire logic sda_oe_in,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_drv;
    // Open-drain data line with pull-up: low while either side pulls
    assign sda_out = sda_drv & ~sda_oe_in;
    // Bus idles released
    initial
    begin
        scl_out = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hp(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // Start when a is high, stop when low; data moves while clock is high
    task automatic cond(input logic a);
        scl_out <= 1'b0;
        hp(4);
        sda_drv <= a;
        hp(12);
        scl_out <= 1'b1;
        hp(16);
        sda_drv <= ~a;
        hp(16);
    endtask
    // One bit: data set while clock low, sampled at end of high phase
    task automatic xbit(input logic b, output logic r);
        scl_out <= 1'b0;
        hp(4);
        sda_drv <= b;
        hp(12);
        scl_out <= 1'b1;
        hp(16);
        r = sda_out;
    endtask
    // Byte most significant bit first, then the ninth bit
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        xbit(1'b1, ack);
    endtask
    // Address, index, data; ok when all three are acknowledged
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
        logic [7:0] t;
        logic k0, k1, k2;
        cond(1'b1);
        xbyte({a, 1'b0}, t, k0);
        xbyte(idx, t, k1);
        xbyte(d, t, k2);
        cond(1'b0);
        ok = !(k0 | k1 | k2);
    endtask
    // Index write, repeated start, one byte read ended by no acknowledge
    task automatic rd(input logic [7:0] idx, output logic [7:0] q, output logic ok);
        logic [7:0] t;
        logic k0, k1, k2, n;
        cond(1'b1);
        xbyte({`LFR_I2C_ADDR, 1'b0}, t, k0);
        xbyte(idx, t, k1);
        cond(1'b1);
        xbyte({`LFR_I2C_ADDR, 1'b1}, t, k2);
        xbyte(8'hFF, q, n);
        cond(1'b0);
        ok = !(k0 | k1 | k2);
    endtask
endmodule

// *** verification/lfr_top_tb_top.sv ***
// Self-checking bench for the LED fault and register block
`include "lfr_cfg.svh"
module lfr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic bchg = 1'b0;
    logic scl, sda, oe, ok, lso, halt;
    logic [7:0] q, r, br, pw;
    logic [3:0] en;
    logic [1:0] th;
    logic [4:0] ff;
    logic [31:0] seed = 32'd90469;
    lfr_pkg::lfr_fault_pins_t fp = '0;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    lfr_top #(.OCP_WIN_CYCLES(20), .OCP_BLANK_CYCLES(50)) i_dut (.sys_clk_in(clk), .srst_in(srst), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe_out(oe), .fault_pins_in(fp), .brightness_change_in(bchg), .enable_out(en),
        .brightness_control_out(br), .pwm_control_out(pw), .ocp_threshold_out(th), .low_side_switch_off_out(lso),
        .boost_halt_out(halt), .fault_flags_out(ff));
    lfr_host_model i_host (.sys_clk_in(clk), .sda_oe_in(oe), .scl_out(scl), .sda_out(sda));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Reset read value of each index except fault control 0x1E, which resets to 0x07 but is given as zero here
    function automatic logic [7:0] dflt(input logic [7:0] idx);
        case (idx)
            8'h00: return {4'h0, `LFR_REVISION_CODE};
            8'h10: return {4'h0, `LFR_ENABLE_RST};
            8'h11: return `LFR_BRIGHT_RST;
            8'h12: return `LFR_PWM_RST;
            8'h13: return {6'h00, `LFR_OCP_SEL_RST};
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        i_host.wr(`LFR_I2C_ADDR, idx, d, ok);
        chk(ok, 1);
    endtask
    task automatic rreg(input logic [7:0] idx, input logic [7:0] exp);
        i_host.rd(idx, q, ok);
        chk(ok, 1);
        chk(q, exp);
    endtask
    // Fault pin pulse of n cycles high then n low
    task automatic pulse(input int b, input int n);
        fp[b] <= 1'b1;
        repeat (n) @(posedge clk);
        fp[b] <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_errors++;
            results();
        end
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 8; i++)
            rreg(i[7:0] * 8'h03 & 8'h13, dflt(i[7:0] * 8'h03 & 8'h13));
        $display("test defaults done");
        r = xs();
        i_host.wr(r[6:0] ^ {6'h00, r[6:0] == `LFR_I2C_ADDR}, 8'h10, 8'h00, ok);
        chk(ok, 0);
        chk(en, 4'hF);
        wreg(8'h10, 8'h01);
        wreg(8'h11, r);
        wreg(8'h12, ~r);
        rreg(8'h11, r);
        rreg(8'h12, ~r);
        wreg(8'h10, 8'h00);
        wreg(8'h10, 8'h01);
        chk(pw, `LFR_PWM_RST);
        chk(br, {r[7:1], 1'b1});
        for (int k = 0; k < 4; k++)
        begin
            wreg(8'h13, k[7:0]);
            chk(th, k[1:0]);
        end
        wreg(8'h01, 8'h01);
        rreg(8'h01, 8'h00);
        rreg(8'h11, dflt(8'h11));
        $display("test registers done");
        wreg(8'h1E, 8'h03);
        pulse(1, 6);
        chk(halt, 1);
        chk(en[0], 0);
        wreg(8'h10, 8'h0F);
        rreg(8'h10, 8'h0E);
        rreg(8'h1F, 8'h04);
        rreg(8'h1F, 8'h00);
        wreg(8'h10, 8'h0F);
        rreg(8'h10, 8'h0F);
        pulse(2, 6);
        chk(halt, 0);
        $display("test thermal done");
        pulse(0, 4);
        chk(lso, 1);
        pulse(3, 4);
        chk(lso, 0);
        repeat (40) pulse(0, 4);
        chk(ff, 5'h02);
        chk(en, 4'hF);
        rreg(8'h1F, 8'h02);
        for (int j = 0; j < 10; j++)
        begin
            bchg <= 1'b1;
            @(posedge clk);
            bchg <= 1'b0;
            repeat (5) pulse(0, 4);
        end
        chk(ff, 5'h00);
        $display("test overcurrent done");
        results();
    end
endmodule
